// ---- dpc_defs.svh ----
// constants for the digital port and counter gate block
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH
`define DPC_ADDR_W      4
`define DPC_DATA_W      32
`define DPC_CNT_W       32
`define DPC_LINES       16
`define DPC_GRP_W       8
`define DPC_NCNT        2
`define DPC_A_DIR       4'h0
`define DPC_A_OUT       4'h1
`define DPC_A_IN        4'h2
`define DPC_A_CMP0      4'h3
`define DPC_A_CMP1      4'h4
`define DPC_A_CNT0      4'h5
`define DPC_A_CNT1      4'h6
`define DPC_A_CTRL      4'h7
`define DPC_A_STAT      4'h8
`define DPC_DIR_RST     2'h0
`define DPC_STRAP_DIR   16'hFF00
`define DPC_HOLD_BIT    4'hF
`define DPC_ZERO32      32'h0000_0000
`define DPC_ONE32       32'h0000_0001
`endif

// ---- dpc_pkg.sv ----
// types of the digital port and counter gate block
`include "dpc_defs.svh"
package dpc_pkg;
    typedef struct packed {
        logic [`DPC_ADDR_W-1:0] addr;
        logic [`DPC_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } dpc_req_s;
    typedef enum logic {DPC_CMP_ARMED, DPC_CMP_FIRED} dpc_cmp_e;
    typedef struct packed {
        logic [`DPC_CNT_W-1:0] cnt;
        logic [2:0]            clk_sync;
        logic [1:0]            gate_sync;
        logic                  match;
        dpc_cmp_e              cmp_st;
    } dpc_cnt_s;
    typedef struct packed {
        logic [1:0]                 dir;
        logic [`DPC_LINES-1:0]      out;
        logic [`DPC_LINES-1:0]      in_s1;
        logic [`DPC_LINES-1:0]      in_s2;
        logic [1:0]                 strap_sync;
        logic [`DPC_DATA_W-1:0]     cmp0;
        logic [`DPC_DATA_W-1:0]     cmp1;
        logic [`DPC_NCNT-1:0]       cnt_en;
        logic [`DPC_NCNT-1:0]       cnt_clr;
        logic [`DPC_DATA_W-1:0]     rdata;
    } dpc_top_s;
endpackage

// ---- dpc_counter.sv ----
// one gated up counter with compare-match one-shot
`timescale 1ns/100ps
`include "dpc_defs.svh"
module dpc_counter
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    // control
    input  wire logic                  enable,
    input  wire logic                  clear,
    input  wire logic [`DPC_CNT_W-1:0] compare,
    // pins
    input  wire logic                  ext_clk,
    input  wire logic                  gate,
    // results
    output logic [`DPC_CNT_W-1:0]      count,
    output logic                       match_pulse,
    output logic                       gate_level
);
    dpc_pkg::dpc_cnt_s st_ff;
    dpc_pkg::dpc_cnt_s nxt_st;
    logic              edge_ok;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.clk_sync = {st_ff.clk_sync[1:0], ext_clk};
        nxt_st.gate_sync = {st_ff.gate_sync[0], gate};
        // rising counter clock seen only while gate is high
        edge_ok = st_ff.clk_sync[1] & ~st_ff.clk_sync[2] & st_ff.gate_sync[1]
                  & enable;
        nxt_st.match = 1'b0;
        if (clear)
        begin
            nxt_st.cnt = `DPC_ZERO32;
        end
        else if (edge_ok)
        begin
            nxt_st.cnt = st_ff.cnt + `DPC_ONE32;
        end
        case (st_ff.cmp_st)
            dpc_pkg::DPC_CMP_ARMED:
            begin
                if (st_ff.cnt == compare)
                begin
                    nxt_st.match = 1'b1;
                    nxt_st.cmp_st = dpc_pkg::DPC_CMP_FIRED;
                end
            end
            dpc_pkg::DPC_CMP_FIRED:
            begin
                if (st_ff.cnt != compare)
                begin
                    nxt_st.cmp_st = dpc_pkg::DPC_CMP_ARMED;
                end
            end
            default:
            begin
                nxt_st.cmp_st = dpc_pkg::DPC_CMP_ARMED;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign count       = st_ff.cnt;
    assign match_pulse = st_ff.match;
    assign gate_level  = st_ff.gate_sync[1];
endmodule // dpc_counter

// ---- dpc_port.sv ----
// sixteen-line digital port with two gated counters
//
// Behaviour
// - software sets sixteen line directions in two groups of eight
// - a low input line reads as 0, a high line as 1
// - output bit 1 drives the line high to light the indicator
// - strap in first position: directions come from software
// - strap in second position: fixed eight in (lines 0-7), eight out (lines 8-15)
// - after power-up all lines are inputs until software changes direction or the strap selects the fixed split
// - counter takes external clock edges only while gate is high
// - undriven gate input is held high so counting stays enabled
// - count equal to programmed compare gives one match pulse
`timescale 1ns/100ps
`include "dpc_defs.svh"
module dpc_port
(
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    // register port
    input  wire logic [`DPC_ADDR_W-1:0]   reg_addr,
    input  wire logic [`DPC_DATA_W-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [`DPC_DATA_W-1:0]   reg_rdata,
    // strap, high selects the fixed split
    input  wire logic                     direction_strap,
    // digital lines
    input  wire logic [`DPC_LINES-1:0]    dio_in,
    output logic      [`DPC_LINES-1:0]    dio_out,
    output logic      [`DPC_LINES-1:0]    dio_oe,
    // counter pins
    input  wire logic [`DPC_NCNT-1:0]     cnt_clk_in,
    input  wire logic [`DPC_NCNT-1:0]     cnt_gate_in,
    output logic      [`DPC_NCNT-1:0]     cnt_gate_pu,
    output logic      [`DPC_NCNT-1:0]     cnt_match_out
);
    dpc_pkg::dpc_top_s  st_ff;
    dpc_pkg::dpc_top_s  nxt_st;
    dpc_pkg::dpc_req_s  req;
    logic [`DPC_CNT_W-1:0]  cnt_val [`DPC_NCNT];
    logic [`DPC_DATA_W-1:0] cmp_val [`DPC_NCNT];
    logic [`DPC_NCNT-1:0]   gate_lvl;
    logic [`DPC_LINES-1:0]  dir_eff;
    logic [`DPC_LINES-1:0]  strap_dir;
    logic [`DPC_DATA_W-1:0] rd_mux;
    logic [`DPC_DATA_W-1:0] stat_word;
    logic                   wr_dir;
    logic                   wr_out;
    logic                   wr_cmp0;
    logic                   wr_cmp1;
    logic                   wr_ctrl;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign cmp_val[0] = st_ff.cmp0;
    assign cmp_val[1] = st_ff.cmp1;

    // fixed split: upper group drives, lower group listens
    assign strap_dir = `DPC_STRAP_DIR;

    // effective direction per line, 1 is output
    genvar li;
    generate
        for (li = 0; li < `DPC_LINES; li = li + 1)
        begin : g_dir
            assign dir_eff[li] = st_ff.strap_sync[1] ? strap_dir[li]
                                                     : st_ff.dir[li / `DPC_GRP_W];
        end
    endgenerate

    // one strobe per writable register
    always_comb
    begin
        wr_dir  = 1'b0;
        wr_out  = 1'b0;
        wr_cmp0 = 1'b0;
        wr_cmp1 = 1'b0;
        wr_ctrl = 1'b0;
        if (req.wr)
        begin
            case (req.addr)
                `DPC_A_DIR:
                begin
                    wr_dir = 1'b1;
                end
                `DPC_A_OUT:
                begin
                    wr_out = 1'b1;
                end
                `DPC_A_CMP0:
                begin
                    wr_cmp0 = 1'b1;
                end
                `DPC_A_CMP1:
                begin
                    wr_cmp1 = 1'b1;
                end
                `DPC_A_CTRL:
                begin
                    wr_ctrl = 1'b1;
                end
                default:
                begin
                    wr_dir = 1'b0;
                end
            endcase
        end
    end

    // status word: gate levels, strap, effective directions
    assign stat_word = {13'h0, gate_lvl, st_ff.strap_sync[1], dir_eff};

    // read data selected by index, unmapped reads give zero
    always_comb
    begin
        rd_mux = '0;
        case (req.addr)
            `DPC_A_DIR:
            begin
                rd_mux = {30'h0, st_ff.dir};
            end
            `DPC_A_OUT:
            begin
                rd_mux = {16'h0, st_ff.out};
            end
            `DPC_A_IN:
            begin
                rd_mux = {16'h0, st_ff.in_s2};
            end
            `DPC_A_CMP0:
            begin
                rd_mux = st_ff.cmp0;
            end
            `DPC_A_CMP1:
            begin
                rd_mux = st_ff.cmp1;
            end
            `DPC_A_CNT0:
            begin
                rd_mux = cnt_val[0];
            end
            `DPC_A_CNT1:
            begin
                rd_mux = cnt_val[1];
            end
            `DPC_A_CTRL:
            begin
                rd_mux = {30'h0, st_ff.cnt_en};
            end
            `DPC_A_STAT:
            begin
                rd_mux = stat_word;
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.in_s1 = dio_in;
        nxt_st.in_s2 = st_ff.in_s1;
        nxt_st.strap_sync = {st_ff.strap_sync[0], direction_strap};
        nxt_st.cnt_clr = '0;
        nxt_st.rdata = '0;
        if (wr_dir)
        begin
            nxt_st.dir = req.wdata[1:0];
        end
        if (wr_out)
        begin
            nxt_st.out = req.wdata[`DPC_LINES-1:0];
        end
        if (wr_cmp0)
        begin
            nxt_st.cmp0 = req.wdata;
        end
        if (wr_cmp1)
        begin
            nxt_st.cmp1 = req.wdata;
        end
        if (wr_ctrl)
        begin
            nxt_st.cnt_en  = req.wdata[1:0];
            nxt_st.cnt_clr = req.wdata[3:2];
        end
        if (req.rd)
        begin
            nxt_st.rdata = rd_mux;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff     <= '0;
            st_ff.dir <= `DPC_DIR_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // level on pin equals register bit
    assign dio_out     = st_ff.out;
    assign dio_oe      = dir_eff;
    assign reg_rdata   = st_ff.rdata;
    assign cnt_gate_pu = {`DPC_NCNT{1'b1}};

    genvar gi;
    generate
        for (gi = 0; gi < `DPC_NCNT; gi = gi + 1)
        begin : g_cnt
            dpc_counter u_cnt
            (
                .mclk        (mclk),
                .rst_b       (rst_b),
                .enable      (st_ff.cnt_en[gi]),
                .clear       (st_ff.cnt_clr[gi]),
                .compare     (cmp_val[gi]),
                .ext_clk     (cnt_clk_in[gi]),
                .gate        (cnt_gate_in[gi]),
                .count       (cnt_val[gi]),
                .match_pulse (cnt_match_out[gi]),
                .gate_level  (gate_lvl[gi])
            );
        end
    endgenerate
endmodule // dpc_port

// ---- dpc_port_assertions.sv ----
// checker bound to the digital port block
`timescale 1ns/100ps
`include "dpc_defs.svh"
module dpc_port_chk
(
    // clock, reset, register port
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins
    input wire logic        direction_strap,
    input wire logic [15:0] dio_in,
    input wire logic [15:0] dio_out,
    input wire logic [15:0] dio_oe,
    input wire logic [1:0]  cnt_gate_pu,
    input wire logic [1:0]  cnt_match_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic seen_ff;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            seen_ff <= 1'h0;
        else if (direction_strap || (reg_wr && reg_addr == `DPC_A_DIR))
            seen_ff <= 1'h1;
    AST_GATE_PU: assert property (cnt_gate_pu == 2'h3)
        else $error("gate pull-up off");
    AST_PWRUP: assert property (!seen_ff |-> dio_oe == 16'h0000)
        else $error("line driven before setup");
    AST_STRAP_FIX: assert property (direction_strap [*4] |-> dio_oe == 16'hFF00)
        else $error("strap split wrong");
    AST_DIR_SW: assert property ((!direction_strap) [*3] ##0 (reg_wr && reg_addr == 4'h0)
        |=> dio_oe == {{8{$past(reg_wdata[1])}}, {8{$past(reg_wdata[0])}}})
        else $error("group direction wrong");
    AST_OUT_WR: assert property (reg_wr && reg_addr == 4'h1 |=> dio_out == $past(reg_wdata[15:0]))
        else $error("output level wrong");
    AST_IN_READ: assert property (reg_rd && reg_addr == 4'h2
        |=> reg_rdata == {16'h0000, $past(dio_in, 3)}) else $error("input read wrong");
    AST_MATCH0: assert property (cnt_match_out[0] |=> !cnt_match_out[0])
        else $error("match 0 too long");
    AST_MATCH1: assert property (cnt_match_out[1] |=> !cnt_match_out[1])
        else $error("match 1 too long");
    cover property (direction_strap [*4]);
    cover property ($rose(cnt_match_out[0]));
    cover property (reg_rd && reg_addr == 4'h2);
endmodule // dpc_port_chk
bind dpc_port dpc_port_chk chk (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .direction_strap, .dio_in, .dio_out, .dio_oe, .cnt_gate_pu, .cnt_match_out);

// ---- dpc_ext.sv ----
// far side: switches, indicators and gate source
`timescale 1ns/100ps
module dpc_ext
(
    // port lines
    input  wire logic [15:0] dio_out,
    input  wire logic [15:0] dio_oe,
    input  wire logic [15:0] sw,
    output logic      [15:0] dio_in,
    // gate pins
    input  wire logic [1:0]  pu,
    input  wire logic [1:0]  gdrv,
    input  wire logic [1:0]  gval,
    output logic      [1:0]  gate
);
    assign dio_in = (dio_oe & dio_out) | (~dio_oe & sw);
    assign gate = (gdrv & gval) | (~gdrv & pu);
endmodule // dpc_ext

// ---- dio_port_counter_gate_tb.sv ----
// self-checking bench for the digital port block
`timescale 1ns/100ps
`include "dpc_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module dio_port_counter_gate_tb;
    logic        mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, strap = 0;
    logic [3:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [15:0] sw = 16'hA5C3, dio_in, dio_out, dio_oe;
    logic [1:0]  cc = 0, gdrv = 0, gval = 0, gate, pu, match;
    int          error_cnt = 0, checks_done = 0, mcnt = 0, mcnt1 = 0;
    initial forever #12.5 mclk = ~mclk;
    dpc_port dut (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .direction_strap(strap), .dio_in, .dio_out, .dio_oe, .cnt_clk_in(cc),
        .cnt_gate_in(gate), .cnt_gate_pu(pu), .cnt_match_out(match));
    dpc_ext ext (.dio_out, .dio_oe, .sw, .dio_in, .pu, .gdrv, .gval, .gate);
    always @(posedge mclk)
    begin
        if (match[0] === 1'h1) mcnt++;
        if (match[1] === 1'h1) mcnt1++;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic tick(input int n);
        repeat (2 * n) begin @(posedge mclk); cc <= ~cc; cyc(4); end
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'h1;
        cyc(4);
        `CHK(dio_oe, 16'h0000)
        `CHK(pu, 2'h3)
        rd(`DPC_A_IN, 32'h0000_A5C3);
        for (int d = 0; d < 4; d++)
        begin
            wr(`DPC_A_DIR, 32'(d));
            `CHK(dio_oe, {{8{d[1]}}, {8{d[0]}}})
        end
        wr(`DPC_A_DIR, 32'h1);
        wr(`DPC_A_OUT, 32'h0000_1234);
        `CHK(dio_out, 16'h1234)
        cyc(3);
        rd(`DPC_A_IN, 32'h0000_A534);
        @(posedge mclk);
        strap <= 1'h1;
        cyc(3);
        wr(`DPC_A_DIR, 32'h2);
        `CHK(dio_oe, 16'hFF00)
        rd(`DPC_A_STAT, 32'h0007_FF00);
        @(posedge mclk);
        strap <= 1'h0;
        cyc(3);
        `CHK(dio_oe, 16'hFF00)
        wr(`DPC_A_CMP0, 32'h3);
        wr(`DPC_A_CTRL, 32'h5);
        @(posedge mclk);
        gdrv <= 2'h3;
        cyc(3);
        mcnt = 0;
        tick(4);
        rd(`DPC_A_CNT0, 32'h0);
        @(posedge mclk);
        gdrv <= 2'h0;
        cyc(3);
        tick(3);
        rd(`DPC_A_CNT0, 32'h3);
        tick(1);
        `CHK(mcnt, 1)
        rd(`DPC_A_CNT1, 32'h0);
        rd(4'hF, 32'h0);
        wr(`DPC_A_CMP1, 32'h2);
        @(posedge mclk);
        gdrv <= 2'h2;
        wr(`DPC_A_CTRL, 32'h2);
        cyc(3);
        mcnt1 = 0;
        tick(2);
        rd(`DPC_A_CNT1, 32'h0);
        @(posedge mclk);
        gdrv <= 2'h0;
        cyc(3);
        tick(2);
        rd(`DPC_A_CNT1, 32'h2);
        `CHK(mcnt1, 1)
        @(posedge mclk);
        rst_b <= 1'h0;
        cyc(2);
        `CHK(dio_oe, 16'h0000)
        @(posedge mclk);
        rst_b <= 1'h1;
        cyc(4);
        `CHK(dio_oe, 16'h0000)
        rd(`DPC_A_IN, 32'h0000_A5C3);
        tally_and_finish;
    end
endmodule // dio_port_counter_gate_tb
